// >>> rtl/flash_pkg.sv
package flash_pkg;
  // How it works
  // - Status write changes only writable bits.
  // - Lock bits set by non-volatile write never return to zero.
  // - Non-volatile status write needs write enable first.
  // - Host sends opcode, then one status byte, or two after 01h.
  // - Volatile enable 50h precedes volatile status write.
  // - Volatile write cannot clear protect or lock bits.
  // - Reset reloads live status from non-volatile copies.
  // - Non-volatile write runs timed, busy set meanwhile.
  // - Finished non-volatile write clears write enable latch.
  // - Volatile write applies at once, busy stays low.
  // - Quad enable frozen in four-line mode.
  // - 01h with sixteen bits writes registers one, two.
  // - Read 03h: address on rise, data on fall.
  // - Read address increments after every output byte.
  // - Reads while busy are ignored, except status reads.
  // - Plain read only in single-line mode.
  // - Fast read single-line uses eight dummy clocks.
  // - Four-line fast read dummies from parameter field.
  // - Dual output read returns data on two lines.
  // - Host releases IO lines before data output.
  // - Quad output read needs quad enable set.
  // - Dual IO read takes address two bits per clock.
  // - Dual address: IO1 odd bits, IO0 even bits.
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_VWREN   = 8'h50;
  localparam logic [7:0] OP_WRSR1   = 8'h01;
  localparam logic [7:0] OP_WRSR2   = 8'h31;
  localparam logic [7:0] OP_WRSR3   = 8'h11;
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_RDSR2   = 8'h35;
  localparam logic [7:0] OP_RDSR3   = 8'h15;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FREAD   = 8'h0B;
  localparam logic [7:0] OP_DREAD   = 8'h3B;
  localparam logic [7:0] OP_QREAD   = 8'h6B;
  localparam logic [7:0] OP_DIOREAD = 8'hBB;
  localparam logic [7:0] OP_SETPAR  = 8'hC0;
  localparam logic [7:0] OP_RESET   = 8'h99;
  localparam logic [7:0] OP_NONE    = 8'hFF;
  // Writable bits of status registers 3, 2 and 1.
  localparam logic [2:0][7:0] WMASK     = 24'hE0_7BFC;
  localparam logic [2:0][7:0] SR_RST    = 24'h00_0000;
  localparam logic [7:0]      LOCK_MASK = 8'h38;
  localparam int              QUAD_EN_BIT = 1;
  localparam int              PROT_B_BIT = 0;
  localparam logic [1:0]      PAR_RST   = 2'h0;
  localparam logic [3:0]      STD_DUMMY = 4'h8;
  // Controller register map and command word layout.
  localparam logic [11:0] REG_CMD  = 12'h000;
  localparam logic [11:0] REG_TXD  = 12'h004;
  localparam logic [11:0] REG_RXD  = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;
  localparam int CMD_TXN_POS = 8;
  localparam int CMD_DUM_POS = 12;
  localparam int CMD_RXN_POS = 16;
  localparam int CMD_CW_POS  = 24;
  localparam int CMD_AW_POS  = 26;
  localparam int CMD_DW_POS  = 28;
  localparam int CMD_GO_BIT  = 31;
endpackage : flash_pkg

// >>> rtl/flash_link_if.sv
interface flash_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // Undriven lines float high as if pulled up.
  assign io = (h_io_o & h_io_oe) | (d_io_o & d_io_oe)
            | ~(h_io_oe | d_io_oe);

  modport host (output cs_n, sclk, h_io_o, h_io_oe, input io);
  modport dev  (input cs_n, sclk, io, output d_io_o, d_io_oe);
endinterface : flash_link_if

// >>> rtl/sync2.sv
module sync2
#(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
)
(
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      meta_r <= INIT;
      sync_r <= INIT;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule : sync2

// >>> rtl/flash_dev.sv
// Register access over APB and the address map are this design's own decisions.
module flash_dev
#(
  parameter int BUSY_CYCLES = 5000
)
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Mode and status
  input  wire logic four_line_command_mode_in,
  output logic      busy_out,
  // Link
  flash_link_if.dev link
);
  typedef enum logic [5:0] {
    D_CMD   = 6'b000001,
    D_ADDR  = 6'b000010,
    D_DUMMY = 6'b000100,
    D_DATA  = 6'b001000,
    D_WDATA = 6'b010000,
    D_SKIP  = 6'b100000
  } dst_e;

  logic [5:0]       syn;
  logic             cs_n_s;
  logic             sclk_s;
  logic [3:0]       io_s;
  logic             sclk_q_r;
  logic             cs_q_r;
  logic             rise;
  logic             fall;
  logic             cs_rise;
  logic             four_line;
  dst_e             state_r;
  dst_e             cst;
  logic [7:0]       op_r;
  logic [31:0]      sh_r;
  logic [31:0]      sh_in;
  logic [5:0]       cnt_r;
  logic [5:0]       cnt_add;
  logic [5:0]       abits;
  logic [23:0]      addr_r;
  logic [3:0]       dcnt_r;
  logic [3:0]       dummies;
  logic [7:0]       osh_r;
  logic [7:0]       ob;
  logic [7:0]       stat;
  logic [3:0]       ocnt_r;
  logic [2:0]       in_w;
  logic [2:0]       out_w;
  logic [3:0]       io_o_r;
  logic [3:0]       io_oe_r;
  logic [2:0][7:0]  sr_r;
  logic [2:0][7:0]  nv_r;
  logic [2:0][7:0]  pend_r;
  logic [2:0][7:0]  wd;
  logic [2:0][7:0]  m;
  logic [2:0]       pen_r;
  logic [2:0]       wen;
  logic             wr_latch_r;
  logic             vwe_r;
  logic             busy_r;
  logic [23:0]      bcnt_r;
  logic [1:0]       par_r;
  logic             is_stat;

  // Idle levels: deselected, clock low, lines pulled high, so that no
  // false clock edge follows reset.
  sync2 #(.W(6), .INIT(6'h2F)) u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    ({link.cs_n, link.sclk, link.io}),
    .q_out   (syn)
  );

  assign cs_n_s  = syn[5];
  assign sclk_s  = syn[4];
  assign io_s    = syn[3:0];
  assign rise    = sclk_s & ~sclk_q_r & ~cs_n_s;
  assign fall    = ~sclk_s & sclk_q_r & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_q_r;
  assign four_line = four_line_command_mode_in;
  assign is_stat = (op_r == flash_pkg::OP_RDSR1)
                 | (op_r == flash_pkg::OP_RDSR2)
                 | (op_r == flash_pkg::OP_RDSR3);

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
    end
    else
    begin
      sclk_q_r <= sclk_s;
      cs_q_r   <= cs_n_s;
    end
  end

  // Lanes per clock for input and output.
  always_comb
  begin
    in_w = 3'd1;
    if (four_line)
      in_w = 3'd4;
    else if (state_r == D_ADDR && op_r == flash_pkg::OP_DIOREAD)
      in_w = 3'd2;
    out_w = 3'd1;
    if (four_line || op_r == flash_pkg::OP_QREAD)
      out_w = 3'd4;
    else if (op_r == flash_pkg::OP_DREAD || op_r == flash_pkg::OP_DIOREAD)
      out_w = 3'd2;
    abits = (op_r == flash_pkg::OP_DIOREAD) ? 6'd32 : 6'd24;
    dummies = flash_pkg::STD_DUMMY;
    if (op_r == flash_pkg::OP_READ || op_r == flash_pkg::OP_DIOREAD)
      dummies = 4'd0;
    else if (four_line)
      dummies = 4'({1'b0, par_r, 1'b0} + 4'd2);
  end

  // Higher lane holds the earlier, more significant bit.
  always_comb
  begin
    case (in_w)
      3'd4:    sh_in = {sh_r[27:0], io_s};
      3'd2:    sh_in = {sh_r[29:0], io_s[1:0]};
      default: sh_in = {sh_r[30:0], io_s[0]};
    endcase
    cnt_add = cnt_r + {3'b000, in_w};
  end

  // Command acceptance.
  always_comb
  begin
    cst = D_SKIP;
    case (sh_in[7:0])
      flash_pkg::OP_READ:    cst = four_line ? D_SKIP : D_ADDR;
      flash_pkg::OP_FREAD:   cst = D_ADDR;
      flash_pkg::OP_DREAD,
      flash_pkg::OP_DIOREAD: cst = four_line ? D_SKIP : D_ADDR;
      flash_pkg::OP_QREAD:
        cst = (four_line || !sr_r[1][flash_pkg::QUAD_EN_BIT]) ? D_SKIP
              : D_ADDR;
      flash_pkg::OP_RDSR1,
      flash_pkg::OP_RDSR2,
      flash_pkg::OP_RDSR3:   cst = D_DATA;
      flash_pkg::OP_WRSR1,
      flash_pkg::OP_WRSR2,
      flash_pkg::OP_WRSR3,
      flash_pkg::OP_SETPAR:  cst = D_WDATA;
      default:               cst = D_SKIP;
    endcase
    if (busy_r && cst != D_DATA)
      cst = D_SKIP;
  end

  // Array content is a fixed pattern of the address.
  always_comb
  begin
    case (op_r)
      flash_pkg::OP_RDSR1: stat = {sr_r[0][7:2], wr_latch_r, busy_r};
      flash_pkg::OP_RDSR2: stat = sr_r[1];
      default:             stat = sr_r[2];
    endcase
    if (ocnt_r != 4'd0)
      ob = osh_r;
    else if (is_stat)
      ob = stat;
    else
      ob = addr_r[7:0] ^ addr_r[15:8] ^ addr_r[23:16];
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_r <= D_CMD;
      op_r    <= flash_pkg::OP_NONE;
      sh_r    <= 32'h0000_0000;
      cnt_r   <= 6'd0;
      addr_r  <= 24'h00_0000;
      dcnt_r  <= 4'd0;
      osh_r   <= 8'h00;
      ocnt_r  <= 4'd0;
      io_o_r  <= 4'h0;
      io_oe_r <= 4'h0;
    end
    else if (cs_n_s)
    begin
      state_r <= D_CMD;
      cnt_r   <= 6'd0;
      ocnt_r  <= 4'd0;
      io_oe_r <= 4'h0;
    end
    else if (rise)
    begin
      case (state_r)
        D_CMD:
        begin
          sh_r  <= sh_in;
          cnt_r <= cnt_add;
          if (cnt_add == 6'd8)
          begin
            op_r    <= (cst == D_SKIP && busy_r) ? flash_pkg::OP_NONE
                                                 : sh_in[7:0];
            state_r <= cst;
            cnt_r   <= 6'd0;
          end
        end
        D_ADDR:
        begin
          sh_r  <= sh_in;
          cnt_r <= cnt_add;
          if (cnt_add == abits)
          begin
            addr_r  <= (op_r == flash_pkg::OP_DIOREAD) ? sh_in[31:8]
                                                       : sh_in[23:0];
            dcnt_r  <= dummies;
            state_r <= (dummies == 4'd0) ? D_DATA : D_DUMMY;
          end
        end
        D_DUMMY:
        begin
          dcnt_r <= dcnt_r - 4'd1;
          if (dcnt_r == 4'd1)
            state_r <= D_DATA;
        end
        D_WDATA:
        begin
          sh_r  <= sh_in;
          cnt_r <= (cnt_r >= 6'd32) ? cnt_r : cnt_add;
        end
        default:
        begin
        end
      endcase
    end
    else if (fall && state_r == D_DATA)
    begin
      // Data shifts out MSB first on the falling edge.
      case (out_w)
        3'd4:
        begin
          io_o_r  <= ob[7:4];
          io_oe_r <= 4'hF;
        end
        3'd2:
        begin
          io_o_r  <= {2'b00, ob[7:6]};
          io_oe_r <= 4'h3;
        end
        default:
        begin
          io_o_r  <= {2'b00, ob[7], 1'b0};
          io_oe_r <= 4'h2;
        end
      endcase
      osh_r  <= ob << out_w;
      ocnt_r <= 4'(((ocnt_r == 4'd0) ? 4'd8 : ocnt_r) - {1'b0, out_w});
      if (ocnt_r == 4'd0 && !is_stat)
        addr_r <= addr_r + 24'h00_0001;
    end
  end

  // Merge of incoming status bytes.
  always_comb
  begin
    wd[0] = (cnt_r == 6'd16) ? sh_r[15:8] : sh_r[7:0];
    wd[1] = sh_r[7:0];
    wd[2] = sh_r[7:0];
    for (int i = 0; i < 3; i++)
      m[i] = (sr_r[i] & ~flash_pkg::WMASK[i])
           | (wd[i] & flash_pkg::WMASK[i]);
    m[1] = m[1] | ((sr_r[1] | nv_r[1]) & flash_pkg::LOCK_MASK);
    if (four_line)
      m[1][flash_pkg::QUAD_EN_BIT] = sr_r[1][flash_pkg::QUAD_EN_BIT];
    if (vwe_r)
      m[1][flash_pkg::PROT_B_BIT] = m[1][flash_pkg::PROT_B_BIT]
                                  | sr_r[1][flash_pkg::PROT_B_BIT];
    wen = 3'b000;
    if (op_r == flash_pkg::OP_WRSR1 && cnt_r == 6'd16)
      wen = 3'b011;
    else if (cnt_r == 6'd8)
      wen = {op_r == flash_pkg::OP_WRSR3, op_r == flash_pkg::OP_WRSR2,
             op_r == flash_pkg::OP_WRSR1};
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      nv_r   <= flash_pkg::SR_RST;
      sr_r   <= flash_pkg::SR_RST;
      pend_r <= flash_pkg::SR_RST;
      pen_r  <= 3'b000;
      wr_latch_r <= 1'b0;
      vwe_r  <= 1'b0;
      busy_r <= 1'b0;
      bcnt_r <= 24'h00_0000;
      par_r  <= flash_pkg::PAR_RST;
    end
    else if (busy_r)
    begin
      bcnt_r <= bcnt_r - 24'h00_0001;
      if (bcnt_r == 24'h00_0001)
      begin
        for (int i = 0; i < 3; i++)
        begin
          if (pen_r[i])
          begin
            nv_r[i] <= pend_r[i];
            sr_r[i] <= pend_r[i];
          end
        end
        wr_latch_r <= 1'b0;
        busy_r <= 1'b0;
      end
    end
    else if (cs_rise)
    begin
      vwe_r <= state_r == D_SKIP && op_r == flash_pkg::OP_VWREN;
      if (state_r == D_SKIP && op_r == flash_pkg::OP_WREN)
        wr_latch_r <= 1'b1;
      else if (state_r == D_SKIP && op_r == flash_pkg::OP_WRDI)
        wr_latch_r <= 1'b0;
      else if (state_r == D_SKIP && op_r == flash_pkg::OP_RESET)
      begin
        sr_r       <= nv_r;
        par_r      <= flash_pkg::PAR_RST;
        wr_latch_r <= 1'b0;
      end
      else if (state_r == D_WDATA && op_r == flash_pkg::OP_SETPAR)
      begin
        if (cnt_r == 6'd8)
          par_r <= sh_r[5:4];
      end
      else if (state_r == D_WDATA && wen != 3'b000)
      begin
        if (vwe_r)
        begin
          for (int i = 0; i < 3; i++)
            if (wen[i])
              sr_r[i] <= m[i];
        end
        else if (wr_latch_r)
        begin
          pend_r <= m;
          pen_r  <= wen;
          busy_r <= 1'b1;
          bcnt_r <= 24'(BUSY_CYCLES);
        end
        // Otherwise the write is dropped.
      end
    end
  end

  assign busy_out     = busy_r;
  assign link.d_io_o  = io_o_r;
  assign link.d_io_oe = io_oe_r;
endmodule : flash_dev

// >>> rtl/flash_host.sv
module flash_host
#(
  parameter int SCLK_HALF = 8
)
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Link
  flash_link_if.host       link
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_OP   = 6'b000010,
    H_TX   = 6'b000100,
    H_DUM  = 6'b001000,
    H_RX   = 6'b010000,
    H_END  = 6'b100000
  } hst_e;

  hst_e        st_r;
  hst_e        nst;
  logic [11:0] npclk;
  logic [11:0] pclk_r;
  logic [11:0] tcl;
  logic [11:0] rcl;
  logic [31:0] cmd_r;
  logic [31:0] txd_r;
  logic [31:0] rxd_r;
  logic [31:0] samp;
  logic [39:0] osh_r;
  logic [39:0] first;
  logic [7:0]  div_r;
  logic [3:0]  io_s;
  logic [3:0]  io_o_r;
  logic [3:0]  io_oe_r;
  logic [3:0]  dum;
  logic [1:0]  cur;
  logic        tick;
  logic        sclk_r;
  logic        cs_n_r;
  logic        start_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        idle;
  logic        unmapped;
  logic        wr;

  function automatic logic [1:0] wsh(input logic [1:0] c);
    return (c == 2'd3) ? 2'd2 : c;
  endfunction : wsh

  // Returns output enables and levels for the top bits.
  function automatic logic [7:0] drive(input logic [39:0] s,
                                       input logic [1:0]  c);
    case (wsh(c))
      2'd2:    return {4'hF, s[39:36]};
      2'd1:    return {4'h3, 2'b00, s[39:38]};
      default: return {4'h1, 3'b000, s[39]};
    endcase
  endfunction : drive

  sync2 #(.W(4), .INIT(4'hF)) u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (link.io),
    .q_out   (io_s)
  );

  assign idle  = (st_r == H_IDLE) && !start_r;
  assign tick  = div_r == 8'(SCLK_HALF - 1);
  assign dum   = cmd_r[flash_pkg::CMD_DUM_POS +: 4];
  assign first = {cmd_r[7:0], txd_r};
  assign tcl   = 12'({cmd_r[flash_pkg::CMD_TXN_POS +: 3], 3'b000}
                 >> wsh(cmd_r[flash_pkg::CMD_AW_POS +: 2]));
  assign rcl   = 12'({cmd_r[flash_pkg::CMD_RXN_POS +: 8], 3'b000}
                 >> wsh(cmd_r[flash_pkg::CMD_DW_POS +: 2]));

  always_comb
  begin
    cur = cmd_r[flash_pkg::CMD_CW_POS +: 2];
    if (st_r == H_TX)
      cur = cmd_r[flash_pkg::CMD_AW_POS +: 2];
    else if (st_r == H_RX)
      cur = cmd_r[flash_pkg::CMD_DW_POS +: 2];
    case (wsh(cur))
      2'd2:    samp = {rxd_r[27:0], io_s};
      2'd1:    samp = {rxd_r[29:0], io_s[1:0]};
      default: samp = {rxd_r[30:0], io_s[1]};
    endcase
    nst   = H_END;
    npclk = 12'd0;
    if (st_r == H_OP && tcl != 12'd0)
    begin
      nst   = H_TX;
      npclk = tcl;
    end
    else if ((st_r == H_OP || st_r == H_TX) && dum != 4'd0)
    begin
      nst   = H_DUM;
      npclk = {8'h00, dum};
    end
    else if (st_r != H_RX && rcl != 12'd0)
    begin
      nst   = H_RX;
      npclk = rcl;
    end
  end

  // Each command is its own select frame, so enables precede writes.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_r    <= H_IDLE;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      io_o_r  <= 4'h0;
      io_oe_r <= 4'h0;
      div_r   <= 8'h00;
      pclk_r  <= 12'd0;
      osh_r   <= 40'h00_0000_0000;
      rxd_r   <= 32'h0000_0000;
    end
    else if (st_r == H_IDLE)
    begin
      div_r <= 8'h00;
      if (start_r)
      begin
        cs_n_r             <= 1'b0;
        st_r               <= H_OP;
        pclk_r             <= 12'(8 >> wsh(cmd_r[flash_pkg::CMD_CW_POS +: 2]));
        {io_oe_r, io_o_r}  <= drive(first, cmd_r[flash_pkg::CMD_CW_POS +: 2]);
        osh_r              <= first << (3'd1 << wsh(cur));
      end
    end
    else
    begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (tick && st_r == H_END)
      begin
        if (sclk_r)
        begin
          sclk_r  <= 1'b0;
          cs_n_r  <= 1'b1;
          io_oe_r <= 4'h0;
        end
        else
          st_r <= H_IDLE;
      end
      else if (tick && !sclk_r)
      begin
        sclk_r <= 1'b1;
        if (st_r == H_RX)
          rxd_r <= samp;
        pclk_r <= pclk_r - 12'd1;
        if (pclk_r == 12'd1)
        begin
          st_r   <= nst;
          pclk_r <= npclk;
        end
      end
      else if (tick)
      begin
        sclk_r <= 1'b0;
        if (st_r == H_OP || st_r == H_TX)
        begin
          {io_oe_r, io_o_r} <= drive(osh_r, cur);
          osh_r             <= osh_r << (3'd1 << wsh(cur));
        end
        else
          io_oe_r <= 4'h0;
      end
    end
  end

  assign unmapped = !(paddr_in == flash_pkg::REG_CMD
                   || paddr_in == flash_pkg::REG_TXD
                   || paddr_in == flash_pkg::REG_RXD
                   || paddr_in == flash_pkg::REG_STAT);
  assign wr = psel_in && penable_in && pready_r && pwrite_in && !unmapped;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= psel_in && !penable_in;
      pslverr_r <= psel_in && !penable_in && unmapped;
      prdata_r  <= 32'h0000_0000;
      if (psel_in && !penable_in && !pwrite_in)
      begin
        if (paddr_in == flash_pkg::REG_CMD)
          prdata_r <= cmd_r;
        else if (paddr_in == flash_pkg::REG_TXD)
          prdata_r <= txd_r;
        else if (paddr_in == flash_pkg::REG_RXD)
          prdata_r <= rxd_r;
        else if (paddr_in == flash_pkg::REG_STAT)
          prdata_r <= {31'h0000_0000, !idle};
      end
    end
  end

  // Command and data words are locked while a frame runs.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cmd_r   <= 32'h0000_0000;
      txd_r   <= 32'h0000_0000;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      if (wr && idle && paddr_in == flash_pkg::REG_CMD)
      begin
        cmd_r   <= pwdata_in;
        start_r <= pwdata_in[flash_pkg::CMD_GO_BIT];
      end
      if (wr && idle && paddr_in == flash_pkg::REG_TXD)
        txd_r <= pwdata_in;
    end
  end

  assign prdata_out   = prdata_r;
  assign pready_out   = pready_r;
  assign pslverr_out  = pslverr_r;
  assign link.cs_n    = cs_n_r;
  assign link.sclk    = sclk_r;
  assign link.h_io_o  = io_o_r;
  assign link.h_io_oe = io_oe_r;
endmodule : flash_host

// >>> dv/flash_link_properties.sv
module flash_link_properties
(
  // Clock and reset
  input wire logic       mclk_in,
  input wire logic       rst_in,
  // Link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe,
  input wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("clock runs while deselected");
  host_idle_a: assert property (cs_n |-> h_io_oe == 4'h0)
    else $error("host drives while deselected");
  no_clash_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
    else $error("both ends drive one line");
  dev_release_a: assert property ($rose(cs_n) |-> ##4 d_io_oe == 4'h0)
    else $error("device drives after deselect");
  dev_launch_a: assert property
    (!cs_n && $changed(d_io_o & d_io_oe) |-> !sclk && !$past(sclk, 2))
    else $error("device data moves off the falling edge");
  host_launch_a: assert property
    (!cs_n && $changed(h_io_o & h_io_oe) |-> !sclk)
    else $error("host data moves while clock high");
  steady_high_a: assert property (sclk && $past(sclk) |-> $stable(io))
    else $error("line changes while clock high");
  high_phase_a: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("clock high phase length wrong");
  deselect_gap_a: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("deselect gap too short");
  frame_c: cover property ($fell(cs_n));
  dual_c: cover property (d_io_oe == 4'h3);
  quad_c: cover property (d_io_oe == 4'hF);
endmodule : flash_link_properties

// >>> dv/test_flash_status_write_and_read_cmds.sv
module test_flash_status_write_and_read_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ADR = 32'h0102_FE00;
  localparam logic [31:0] DAT = 32'hFDFC_0203;
  localparam logic [31:0] ONE = 32'hFFFF_FFFF;
  localparam logic [31:0] NIL = 32'h0000_0000;
  localparam logic [5:0]  S   = 6'h00;
  localparam logic [5:0]  Q   = 6'h2A;
  logic        mclk_in;
  logic        rst_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        perr;
  logic        four_line;
  logic        busy;
  logic [31:0] rx;
  int          err_total;
  int          n_tests;

  flash_link_if link ();
  flash_host #(.SCLK_HALF(8)) i_flash_host
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .link(link)
  );
  flash_dev #(.BUSY_CYCLES(2000)) i_flash_dev
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .busy_out(busy),
    .four_line_command_mode_in(four_line), .link(link)
  );
  flash_link_properties i_flash_link_properties
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .cs_n(link.cs_n),
    .sclk(link.sclk), .h_io_o(link.h_io_o), .h_io_oe(link.h_io_oe),
    .d_io_o(link.d_io_o), .d_io_oe(link.d_io_oe), .io(link.io)
  );

  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  // The request stands until pready is seen high at a rising edge; the
  // answer is taken at that very edge, before the slave moves on.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do
      @(posedge mclk_in);
    while (pready !== 1'b1);
    rx = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go(input logic [7:0] op, input logic [2:0] ntx,
                    input logic [3:0] dum, input logic [7:0] nrx,
                    input logic [5:0] ln, input logic [31:0] txd);
    apb(1'b1, flash_pkg::REG_TXD, txd);
    apb(1'b1, flash_pkg::REG_CMD, {2'b10, ln, nrx, dum, 1'b0, ntx, op});
    rx = 32'h0000_0001;
    while (rx[0] === 1'b1)
      apb(1'b0, flash_pkg::REG_STAT, NIL);
    apb(1'b0, flash_pkg::REG_RXD, NIL);
  endtask : go

  task automatic wr(input logic [7:0] op, input logic [2:0] ntx,
                    input logic [5:0] ln, input logic [31:0] d);
    go(op, ntx, 4'h0, 8'h00, ln, d);
  endtask : wr

  task automatic sr(input logic [7:0] op, input logic [5:0] ln,
                    input logic [7:0] exp);
    go(op, 3'h0, 4'h0, 8'h01, ln, NIL);
    chk({24'h00_0000, rx[7:0]}, {24'h00_0000, exp});
  endtask : sr

  task automatic rd(input logic [7:0] op, input logic [2:0] ntx,
                    input logic [3:0] dum, input logic [5:0] ln,
                    input logic [31:0] exp);
    go(op, ntx, dum, 8'h04, ln, ADR);
    chk(rx, exp);
  endtask : rd

  task automatic settle();
    while (busy !== 1'b0)
      @(posedge mclk_in);
  endtask : settle

  initial
  begin
    #1_600_000;
    err_total++;
    summarize();
  end

  initial
  begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = NIL;
    four_line = 1'b0;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    sr(8'h05, S, 8'h00);
    wr(8'h06, 3'h0, S, NIL);
    sr(8'h05, S, 8'h02);
    wr(8'h31, 3'h1, S, 32'hFF00_0000);
    sr(8'h05, S, 8'h03);
    rd(8'h03, 3'h3, 4'h0, S, ONE);
    settle();
    sr(8'h05, S, 8'h00);
    sr(8'h35, S, 8'h7B);
    wr(8'h06, 3'h0, S, NIL);
    wr(8'h31, 3'h1, S, 32'h0300_0000);
    settle();
    sr(8'h35, S, 8'h3B);
    wr(8'h50, 3'h0, S, NIL);
    wr(8'h31, 3'h1, S, NIL);
    sr(8'h05, S, 8'h00);
    sr(8'h35, S, 8'h39);
    wr(8'h99, 3'h0, S, NIL);
    sr(8'h35, S, 8'h3B);
    wr(8'h31, 3'h1, S, NIL);
    sr(8'h35, S, 8'h3B);
    wr(8'h06, 3'h0, S, NIL);
    wr(8'h01, 3'h2, S, 32'h4402_0000);
    settle();
    sr(8'h05, S, 8'h44);
    sr(8'h35, S, 8'h3A);
    wr(8'h06, 3'h0, S, NIL);
    wr(8'h01, 3'h1, S, NIL);
    settle();
    sr(8'h05, S, 8'h00);
    sr(8'h35, S, 8'h3A);
    rd(8'h03, 3'h3, 4'h0, S, DAT);
    rd(8'h0B, 3'h3, 4'h8, S, DAT);
    rd(8'h3B, 3'h3, 4'h8, 6'h10, DAT);
    rd(8'h6B, 3'h3, 4'h8, 6'h20, DAT);
    rd(8'hBB, 3'h4, 4'h0, 6'h14, DAT);
    apb(1'b0, 12'h010, NIL);
    chk({31'h0000_0000, perr}, 32'h0000_0001);
    four_line <= 1'b1;
    rd(8'h03, 3'h3, 4'h0, Q, ONE);
    rd(8'h0B, 3'h3, 4'h2, Q, DAT);
    wr(8'h06, 3'h0, Q, NIL);
    wr(8'h31, 3'h1, Q, 32'h3800_0000);
    settle();
    sr(8'h35, Q, 8'h3A);
    wr(8'hC0, 3'h1, Q, 32'h3000_0000);
    rd(8'h0B, 3'h3, 4'h8, Q, DAT);
    summarize();
  end
endmodule : test_flash_status_write_and_read_cmds
